// ### gfc_pkg.sv
// Constants, field layout and types of the multifunction pin block
package gfc_pkg;

  // Register addresses, direct and PMBus alias
  localparam logic [7:0] PIN_CFG_ADDR      = 8'h24;
  localparam logic [7:0] DEV_MODE_ADDR     = 8'h25;
  localparam logic [7:0] PMB_PIN_CFG_CODE  = 8'he8;
  localparam logic [7:0] PMB_DEV_MODE_CODE = 8'he9;
  localparam logic [7:0] PMB_PAGE          = 8'hff;

  // Values after reset
  localparam logic [15:0] PIN_CFG_RESET  = 16'h0000;
  localparam logic [15:0] DEV_MODE_RESET = 16'h0000;
  // Bit 14 of the pin register is not stored
  localparam logic [15:0] PIN_CFG_MASK   = 16'hbfff;

  // Pin configuration fields
  localparam int FILT_BIT   = 15;
  localparam int OUT_EN_BIT = 13;
  localparam int OSEL_LSB   = 9;
  localparam int CHM_LSB    = 5;
  localparam int IFN_LSB    = 1;
  localparam int IN_EN_BIT  = 0;
  localparam int FIELD_W    = 4;
  // Channel mask bits
  localparam int CHM_CH1_BIT = 0;
  localparam int CHM_CH0_BIT = 3;

  // Device mode fields
  localparam int LOWPWR_BIT = 13;
  localparam int SHUT_LSB   = 8;

  // Output select codes
  localparam logic [3:0] OSEL_MEM_BUSY = 4'h1;
  localparam logic [3:0] OSEL_CH1_BUSY = 4'h4;
  localparam logic [3:0] OSEL_CH0_BUSY = 4'h7;
  localparam logic [3:0] OSEL_CH1_WIN  = 4'h8;
  localparam logic [3:0] OSEL_CH0_WIN  = 4'hb;

  // Input function codes
  localparam logic [3:0] IFN_FAULT_DUMP = 4'h2;
  localparam logic [3:0] IFN_CUR_PWR    = 4'h3;
  localparam logic [3:0] IFN_VOLT_PWR   = 4'h4;
  localparam logic [3:0] IFN_SHUTDOWN   = 4'h5;
  localparam logic [3:0] IFN_CLEAR      = 4'h7;
  localparam logic [3:0] IFN_LOAD       = 4'h8;
  localparam logic [3:0] IFN_WAVE       = 4'h9;
  localparam logic [3:0] IFN_MARGIN     = 4'ha;
  localparam logic [3:0] IFN_RESET      = 4'hb;
  localparam logic [3:0] IFN_NVM_WP     = 4'hc;
  localparam logic [3:0] IFN_MAP_LOCK   = 4'hd;

  // Shutdown behaviours
  typedef enum logic [1:0] {
    GFC_SHUT_HIZ,
    GFC_SHUT_STORED,
    GFC_SHUT_MARGIN_LO,
    GFC_SHUT_MARGIN_HI
  } gfc_shut_t;

  // Glitch filter timing
  localparam int CLK_MHZ       = 25;
  localparam int FILTER_NS     = 100;
  localparam int FILTER_CYCLES = (FILTER_NS * CLK_MHZ + 999) / 1000;

endpackage

// ### gfc_glitch_filter.sv
// Glitch filter: output follows input only after it stays stable
`timescale 1ns/1ps
module gfc_glitch_filter #(
  parameter int STABLE_CYCLES = gfc_pkg::FILTER_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rstSyncN,
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic       last;
    logic [7:0] count;
    logic       value;
  } gfc_filt_t;

  gfc_filt_t filt_reg;
  gfc_filt_t filt_next;

  always_comb begin
    filt_next = filt_reg;
    filt_next.last = din;
    if (din != filt_reg.last) begin
      filt_next.count = 8'h00;
    end else if (filt_reg.count < 8'(STABLE_CYCLES)) begin
      filt_next.count = filt_reg.count + 8'h01;
    end else begin
      filt_next.value = din;
    end
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      filt_reg <= '{last: 1'b1, count: 8'h00, value: 1'b1};
    end else begin
      filt_reg <= filt_next;
    end
  end

  assign dout = filt_reg.value;

endmodule

// ### gfc_pin_function.sv
// Multifunction pin: configuration registers, output status mux, input actions
`timescale 1ns/1ps
module gfc_pin_function #(
  parameter int FILTER_CYCLES = gfc_pkg::FILTER_CYCLES
) (
  input  wire logic                mclk,
  input  wire logic                rstn,
  // Pin, split into its three signals
  input  wire logic                pinIn,
  output logic                     pinOut,
  output logic                     pinOe,
  // Register access from the serial interface logic
  input  wire logic                pmbusMode,
  input  wire logic [7:0]          pmbusPage,
  input  wire logic [7:0]          regAddr,
  input  wire logic                regWrEn,
  input  wire logic [15:0]         regWrData,
  input  wire logic                regRdEn,
  output logic [15:0]              regRdData,
  output logic                     regRdValid,
  input  wire logic                regWrUnlockField,
  input  wire logic                regWrResetField,
  input  wire logic                regWrViaI2c,
  output logic                     mapWriteAllow,
  // Status sources for the output mux
  input  wire logic                memoryBusy,
  input  wire logic                chan0Busy,
  input  wire logic                chan1Busy,
  input  wire logic                chan0WindowResult,
  input  wire logic                chan1WindowResult,
  // Per-channel settings, index 0 is channel 0
  input  wire logic [1:0]          chanSyncUpdateSetting,
  // Stored configuration image for reload after pin reset
  input  wire logic                nvmPinCfgSaved,
  input  wire logic [15:0]         nvmPinCfgImage,
  // Actions
  output logic                     faultDumpPulse,
  output logic                     shutdownStartPulse,
  output logic                     clearOutputs,
  output logic [1:0]               currentOutputPowerDown,
  output logic [1:0]               voltageOutputPowerDown,
  output logic [1:0]               outputLoadUpdatePulse,
  output logic [1:0]               waveStartPulse,
  output logic [1:0]               waveStopPulse,
  output logic [1:0]               marginLowPulse,
  output logic [1:0]               marginHighPulse,
  output logic                     deviceResetHold,
  output logic                     nvmProgramAllow,
  output logic                     mapLocked,
  // Mode register fields
  output logic                     lowPowerSelect,
  output gfc_pkg::gfc_shut_t       shutdownAction
);

  typedef struct packed {
    logic        pinSync1;
    logic        pinSync2;
    logic        pinPrev;
    logic        pinValid;
    logic [15:0] pinCfg;
    logic [15:0] devMode;
    logic        pinOutVal;
    logic [15:0] rdData;
    logic        rdValid;
    logic        faultDump;
    logic        shutStart;
    logic        clearOut;
    logic [1:0]  curPd;
    logic [1:0]  voltPd;
    logic [1:0]  loadUpd;
    logic [1:0]  waveStart;
    logic [1:0]  waveStop;
    logic [1:0]  marLo;
    logic [1:0]  marHi;
    logic        devReset;
    logic        nvmAllow;
    logic        locked;
  } gfc_state_t;

  gfc_state_t st_reg;
  gfc_state_t st_next;

  logic [1:0] rstPipe;
  logic       rstSyncN;
  logic       pinFiltered;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe[1];

  // Filter always runs, so enabling it finds a settled history
  gfc_glitch_filter #(
    .STABLE_CYCLES (FILTER_CYCLES)
  ) u_filter (
    .mclk     (mclk),
    .rstSyncN (rstSyncN),
    .din      (st_reg.pinSync2),
    .dout     (pinFiltered)
  );

  // Address hit in direct or PMBus space
  function automatic logic addrHit(input logic pmb, input logic [7:0] page,
                                   input logic [7:0] addr, input logic [7:0] direct,
                                   input logic [7:0] code);
    addrHit = pmb ? (page == gfc_pkg::PMB_PAGE && addr == code) : (addr == direct);
  endfunction

  // Four-bit field of the pin register from its lowest bit
  function automatic logic [3:0] cfgField(input logic [15:0] cfg,
                                          input int          lsb);
    cfgField = cfg[lsb +: gfc_pkg::FIELD_W];
  endfunction

  // Word as stored, with the unused bit held at zero
  function automatic logic [15:0] storeCfg(input logic [15:0] word);
    storeCfg = word & gfc_pkg::PIN_CFG_MASK;
  endfunction

  // One pulse for each enabled channel on a detected edge
  function automatic logic [1:0] chanPulse(input logic       hit,
                                           input logic [1:0] mask);
    chanPulse = {2{hit}} & mask;
  endfunction

  // Decoded view of the current configuration
  logic [3:0] outSel;
  logic [3:0] inFunc;
  logic [1:0] chanEn;
  logic       pinLevel;
  logic       fallEdge;
  logic       riseEdge;
  logic       hitCfg;
  logic       hitMode;
  logic       writeOk;

  always_comb begin
    outSel   = cfgField(st_reg.pinCfg, gfc_pkg::OSEL_LSB);
    inFunc   = cfgField(st_reg.pinCfg, gfc_pkg::IFN_LSB);
    // Mask bit 0 is channel 1, bit 3 is channel 0
    chanEn   = {st_reg.pinCfg[gfc_pkg::CHM_LSB + gfc_pkg::CHM_CH1_BIT],
                st_reg.pinCfg[gfc_pkg::CHM_LSB + gfc_pkg::CHM_CH0_BIT]};
    pinLevel = st_reg.pinCfg[gfc_pkg::FILT_BIT] ? pinFiltered : st_reg.pinSync2;
    fallEdge = st_reg.pinValid & st_reg.pinPrev & ~pinLevel;
    riseEdge = st_reg.pinValid & ~st_reg.pinPrev & pinLevel;
    hitCfg   = addrHit(pmbusMode, pmbusPage, regAddr,
                       gfc_pkg::PIN_CFG_ADDR, gfc_pkg::PMB_PIN_CFG_CODE);
    hitMode  = addrHit(pmbusMode, pmbusPage, regAddr,
                       gfc_pkg::DEV_MODE_ADDR, gfc_pkg::PMB_DEV_MODE_CODE);
    writeOk  = ~st_reg.locked;

    st_next = st_reg;
    // Two-flop synchroniser for the pin
    st_next.pinSync1  = pinIn;
    st_next.pinSync2  = st_reg.pinSync1;
    // Previous level from the same source, so a filter switch while idle is no edge
    st_next.pinPrev   = pinLevel;
    st_next.pinValid  = 1'b1;
    // Pulses last one cycle unless renewed
    st_next.faultDump = 1'b0;
    st_next.shutStart = 1'b0;
    st_next.clearOut  = 1'b0;
    st_next.loadUpd   = 2'b00;
    st_next.waveStart = 2'b00;
    st_next.waveStop  = 2'b00;
    st_next.marLo     = 2'b00;
    st_next.marHi     = 2'b00;

    // Status routed to the pin
    // Unused codes park the pin low
    unique case (outSel)
      gfc_pkg::OSEL_MEM_BUSY: st_next.pinOutVal = memoryBusy;
      gfc_pkg::OSEL_CH1_BUSY: st_next.pinOutVal = chan1Busy;
      gfc_pkg::OSEL_CH0_BUSY: st_next.pinOutVal = chan0Busy;
      gfc_pkg::OSEL_CH1_WIN:  st_next.pinOutVal = chan1WindowResult;
      gfc_pkg::OSEL_CH0_WIN:  st_next.pinOutVal = chan0WindowResult;
      default:                st_next.pinOutVal = 1'b0;
    endcase

    // Register writes, blocked while the map is locked
    // Pin actions below ignore the lock
    if (regWrEn && writeOk) begin
      if (hitCfg) begin
        st_next.pinCfg = storeCfg(regWrData);
      end
      if (hitMode) begin
        st_next.devMode = regWrData;
      end
    end

    // Input actions
    if (st_reg.pinCfg[gfc_pkg::IN_EN_BIT]) begin
      unique case (inFunc)
        gfc_pkg::IFN_FAULT_DUMP: st_next.faultDump = fallEdge;
        gfc_pkg::IFN_CUR_PWR: begin
          if (fallEdge) begin
            st_next.curPd = st_reg.curPd | chanEn;
          end else if (riseEdge) begin
            st_next.curPd = st_reg.curPd & ~chanEn;
          end
        end
        gfc_pkg::IFN_VOLT_PWR: begin
          if (fallEdge) begin
            st_next.voltPd = st_reg.voltPd | chanEn;
          end else if (riseEdge) begin
            st_next.voltPd = st_reg.voltPd & ~chanEn;
          end
        end
        gfc_pkg::IFN_SHUTDOWN: st_next.shutStart = fallEdge;
        gfc_pkg::IFN_CLEAR:    st_next.clearOut = ~pinLevel;
        gfc_pkg::IFN_LOAD: begin
          st_next.loadUpd = chanPulse(fallEdge, chanEn & chanSyncUpdateSetting);
        end
        gfc_pkg::IFN_WAVE: begin
          st_next.waveStop  = chanPulse(fallEdge, chanEn);
          st_next.waveStart = chanPulse(riseEdge, chanEn);
        end
        gfc_pkg::IFN_MARGIN: begin
          st_next.marLo = chanPulse(fallEdge, chanEn);
          st_next.marHi = chanPulse(riseEdge, chanEn);
        end
        gfc_pkg::IFN_RESET: begin
          if (fallEdge) begin
            st_next.devReset = 1'b1;
          end else if (riseEdge && st_reg.devReset) begin
            st_next.devReset = 1'b0;
            // Reload wins over a write in the same cycle
            st_next.pinCfg   = nvmPinCfgSaved ? storeCfg(nvmPinCfgImage)
                                              : gfc_pkg::PIN_CFG_RESET;
            st_next.devMode  = gfc_pkg::DEV_MODE_RESET;
            // Outputs powered up, programming blocked, map unlocked
            st_next.curPd    = 2'b00;
            st_next.voltPd   = 2'b00;
            st_next.nvmAllow = 1'b0;
            st_next.locked   = 1'b0;
          end
        end
        gfc_pkg::IFN_NVM_WP: begin
          if (fallEdge) begin
            st_next.nvmAllow = 1'b1;
          end else if (riseEdge) begin
            st_next.nvmAllow = 1'b0;
          end
        end
        gfc_pkg::IFN_MAP_LOCK: begin
          if (fallEdge) begin
            st_next.locked = 1'b0;
          end else if (riseEdge) begin
            st_next.locked = 1'b1;
          end
        end
        default: begin
          // Invalid code, no action
        end
      endcase
    end

    // Read answer one cycle after the request
    // A write in the same cycle is not yet visible
    st_next.rdValid = regRdEn;
    if (regRdEn) begin
      if (hitCfg) begin
        st_next.rdData = st_reg.pinCfg;
      end else if (hitMode) begin
        st_next.rdData = st_reg.devMode;
      end else begin
        st_next.rdData = 16'h0000;
      end
    end
  end

  // Whole state registered on the synchronised reset
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      st_reg <= '{pinSync1: 1'b1, pinSync2: 1'b1, pinPrev: 1'b1,
                  pinValid: 1'b0, pinCfg: gfc_pkg::PIN_CFG_RESET,
                  devMode: gfc_pkg::DEV_MODE_RESET,
                  pinOutVal: 1'b0, rdData: 16'h0000, rdValid: 1'b0,
                  faultDump: 1'b0, shutStart: 1'b0, clearOut: 1'b0,
                  curPd: 2'b00, voltPd: 2'b00, loadUpd: 2'b00,
                  waveStart: 2'b00, waveStop: 2'b00, marLo: 2'b00,
                  marHi: 2'b00, devReset: 1'b0, nvmAllow: 1'b0,
                  locked: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pinOe                  = st_reg.pinCfg[gfc_pkg::OUT_EN_BIT];
  // Pin low whenever the output drive is off
  assign pinOut                 = st_reg.pinOutVal & pinOe;
  assign regRdData              = st_reg.rdData;
  assign regRdValid             = st_reg.rdValid;
  // Unlock key always, reset field only over I2C
  assign mapWriteAllow          = ~st_reg.locked | regWrUnlockField
                                  | (regWrResetField & regWrViaI2c);
  assign faultDumpPulse         = st_reg.faultDump;
  assign shutdownStartPulse     = st_reg.shutStart;
  assign clearOutputs           = st_reg.clearOut;
  assign currentOutputPowerDown = st_reg.curPd;
  assign voltageOutputPowerDown = st_reg.voltPd;
  assign outputLoadUpdatePulse  = st_reg.loadUpd;
  assign waveStartPulse         = st_reg.waveStart;
  assign waveStopPulse          = st_reg.waveStop;
  assign marginLowPulse         = st_reg.marLo;
  assign marginHighPulse        = st_reg.marHi;
  assign deviceResetHold        = st_reg.devReset;
  assign nvmProgramAllow        = st_reg.nvmAllow;
  assign mapLocked              = st_reg.locked;
  assign lowPowerSelect         = st_reg.devMode[gfc_pkg::LOWPWR_BIT];
  assign shutdownAction         = gfc_pkg::gfc_shut_t'(st_reg.devMode[gfc_pkg::SHUT_LSB +: 2]);

endmodule

// ### gfc_pin_function_asserts.sv
// Checker of the multifunction pin block, bound to its top module
`timescale 1ns/1ps
module gfc_pin_function_chk (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        pinIn,
  input wire logic        pinOut,
  input wire logic        pinOe,
  input wire logic        regRdEn,
  input wire logic        regRdValid,
  input wire logic [15:0] regRdData,
  input wire logic        regWrUnlockField,
  input wire logic        regWrResetField,
  input wire logic        regWrViaI2c,
  input wire logic        mapWriteAllow,
  input wire logic        mapLocked,
  input wire logic        faultDumpPulse,
  input wire logic        shutdownStartPulse,
  input wire logic        clearOutputs,
  input wire logic        deviceResetHold
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  AST_RD_ANSWER: assert property (regRdEn |=> regRdValid)
    else $error("read answer missing");
  AST_RD_CAUSE: assert property (regRdValid |-> $past(regRdEn))
    else $error("read answer without request");
  AST_RD_HOLD: assert property (!regRdValid |-> $stable(regRdData))
    else $error("read data changed without answer");
  AST_WR_ALLOW: assert property (mapWriteAllow == (!mapLocked || regWrUnlockField ||
    (regWrResetField && regWrViaI2c))) else $error("map write permission wrong");
  AST_OE_GATE: assert property (!pinOe |-> !pinOut)
    else $error("pin driven high with output off");
  AST_FAULT_CAUSE: assert property (faultDumpPulse |-> !$past(pinIn, 3))
    else $error("fault dump without low pin");
  AST_FAULT_ONCE: assert property (faultDumpPulse |=> !faultDumpPulse)
    else $error("fault dump longer than one cycle");
  AST_SHUT_ONCE: assert property (shutdownStartPulse |=> !shutdownStartPulse)
    else $error("shutdown start longer than one cycle");
  AST_CLEAR_CAUSE: assert property ($rose(clearOutputs) |-> !$past(pinIn, 3))
    else $error("clear raised without low pin");
  AST_RST_RELEASE: assert property ($fell(deviceResetHold) |-> $past(pinIn, 3))
    else $error("reset released without high pin");
  AST_LOCK_CAUSE: assert property ($rose(mapLocked) |-> $past(pinIn, 3))
    else $error("lock set without high pin");
  cover property (faultDumpPulse);
  cover property (deviceResetHold);
  cover property (pinOe && pinOut);
endmodule

bind gfc_pin_function gfc_pin_function_chk chk (.*);

// ### gfc_pin_partner.sv
// Far-side logic that drives or samples the multifunction pin
`timescale 1ns/1ps
module gfc_pin_partner (
  input  wire logic mclk,
  input  wire logic pinOut,
  input  wire logic pinOe,
  input  wire logic extOe,
  input  wire logic extLevel,
  output logic      pinIn,
  output logic      seenLevel
);
  // Wire level: device drive first, then far side, else pull-up
  assign pinIn = pinOe ? pinOut : (extOe ? extLevel : 1'b1);
  always_ff @(posedge mclk) begin
    seenLevel <= pinIn;
  end
endmodule

// ### gfc_pin_function_test.sv
// Self-checking bench of the multifunction pin block
`timescale 1ns/1ps
module gfc_pin_function_test;
  logic               mclk, rstn, pinIn, pinOut, pinOe, pmbusMode, regWrEn, regRdEn;
  logic [7:0]         pmbusPage, regAddr;
  logic [15:0]        regWrData, regRdData, nvmPinCfgImage;
  logic               regRdValid, regWrUnlockField, regWrResetField, regWrViaI2c;
  logic               mapWriteAllow, nvmPinCfgSaved, faultDumpPulse, shutdownStartPulse;
  logic               clearOutputs, deviceResetHold, nvmProgramAllow, mapLocked;
  logic               lowPowerSelect, extOe, extLevel, seenLevel;
  logic [1:0]         chanSyncUpdateSetting, curPd, voltPd, loadP, startP, stopP, lowP, highP;
  gfc_pkg::gfc_shut_t shutdownAction;
  logic [4:0]         src;
  logic [11:0]        pv;
  logic [7:0]         lv;
  int                 cnt[12];
  int                 errors, total_checks, cycles;
  localparam logic [15:0] CFG [11] = '{16'h0125, 16'h0127, 16'h0029, 16'h012b, 16'h012f,
    16'h0131, 16'h0113, 16'h0135, 16'h0139, 16'h012d, 16'h0124};
  localparam logic [11:0] FP [11] = '{12'h800, 12'h0, 12'h0, 12'h400, 12'h0, 12'h100,
    12'h010, 12'h00c, 12'h0, 12'h0, 12'h0};
  localparam logic [7:0] FL [11] = '{8'h0, 8'h60, 8'h10, 8'h0, 8'h80, 8'h0, 8'h0, 8'h0,
    8'h02, 8'h0, 8'h0};
  localparam logic [11:0] RP [11] = '{12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h040,
    12'h003, 12'h0, 12'h0, 12'h0};
  localparam logic [3:0] OSEL [5] = '{4'h1, 4'h4, 4'h7, 4'h8, 4'hb};

  logic memoryBusy, chan0Busy, chan1Busy, chan0WindowResult, chan1WindowResult;
  assign {memoryBusy, chan1Busy, chan0Busy, chan1WindowResult, chan0WindowResult} = src;
  assign pv = {faultDumpPulse, shutdownStartPulse, loadP, startP, stopP, lowP, highP};
  assign lv = {clearOutputs, curPd, voltPd, deviceResetHold, nvmProgramAllow, mapLocked};

  gfc_pin_function #(.FILTER_CYCLES(3)) dut (.mclk, .rstn, .pinIn, .pinOut, .pinOe,
    .pmbusMode, .pmbusPage, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData,
    .regRdValid, .regWrUnlockField, .regWrResetField, .regWrViaI2c, .mapWriteAllow,
    .memoryBusy, .chan0Busy, .chan1Busy, .chan0WindowResult, .chan1WindowResult,
    .chanSyncUpdateSetting, .nvmPinCfgSaved, .nvmPinCfgImage, .faultDumpPulse,
    .shutdownStartPulse, .clearOutputs, .currentOutputPowerDown(curPd),
    .voltageOutputPowerDown(voltPd), .outputLoadUpdatePulse(loadP), .waveStartPulse(startP),
    .waveStopPulse(stopP), .marginLowPulse(lowP), .marginHighPulse(highP), .deviceResetHold,
    .nvmProgramAllow, .mapLocked, .lowPowerSelect, .shutdownAction);
  gfc_pin_partner far (.mclk, .pinOut, .pinOe, .extOe, .extLevel, .pinIn, .seenLevel);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    foreach (pv[i]) if (pv[i] === 1'b1) cnt[i]++;
    cycles++;
    if (cycles == 4000) begin
      errors++;
      finish_test;
    end
  end

  task finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask

  task step(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge mclk);
    regWrEn <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge mclk);
    regRdEn <= 1'b0;
    #1;
    chk("rdValid", 16'h1, 16'(regRdValid));
    chk("rdData", e, regRdData);
  endtask

  // Moves the pin, then checks pulses seen and levels left
  task pinTo(input logic l, input logic [11:0] ep, input logic [7:0] el);
    logic [11:0] got;
    logic        multi;
    @(posedge mclk) extLevel <= l;
    #1 cnt = '{default: 0};
    step(14);
    #1 multi = 1'b0;
    foreach (cnt[i]) begin
      got[i] = cnt[i] != 0;
      multi |= cnt[i] > 1;
    end
    chk("pulses", 16'(ep), 16'(got));
    chk("repeats", 16'h0, 16'(multi));
    chk("levels", 16'(el), 16'(lv));
  endtask

  initial begin
    rstn = 1'b0;
    {pmbusMode, regWrEn, regRdEn, regWrUnlockField, regWrResetField, regWrViaI2c} = '0;
    {pmbusPage, regAddr, regWrData, src, nvmPinCfgSaved} = '0;
    {extOe, extLevel} = 2'b11;
    chanSyncUpdateSetting = 2'b01;
    nvmPinCfgImage = 16'h0017;
    {errors, total_checks, cycles} = '0;
    cnt = '{default: 0};
    step(10);
    rstn <= 1'b1;
    step(3);
    rd(8'h24, 16'h0000);
    rd(8'h25, 16'h0000);
    for (int i = 0; i < 11; i++) begin
      wr(8'h24, CFG[i]);
      rd(8'h24, CFG[i]);
      pinTo(1'b0, FP[i], FL[i]);
      pinTo(1'b1, RP[i], 8'h00);
      wr(8'h24, 16'h0000);
    end
    // Single-cycle glitch: passes unfiltered, rejected when filtered
    wr(8'h24, 16'h0125);
    @(posedge mclk) extLevel <= 1'b0;
    pinTo(1'b1, 12'h800, 8'h00);
    wr(8'h24, 16'h8125);
    @(posedge mclk) extLevel <= 1'b0;
    pinTo(1'b1, 12'h000, 8'h00);
    pinTo(1'b0, 12'h800, 8'h00);
    pinTo(1'b1, 12'h000, 8'h00);
    @(posedge mclk) extOe <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      wr(8'h24, {3'b001, OSEL[k], 9'h000});
      @(posedge mclk) src <= 5'h10 >> k;
      step(2);
      #1 chk("pinOut", 16'h1, 16'(pinOut));
      chk("pinWire", 16'h1, 16'(seenLevel));
      @(posedge mclk) src <= ~(5'h10 >> k);
      step(2);
      #1 chk("pinOut", 16'h0, 16'(pinOut));
    end
    wr(8'h24, {3'b001, 4'h2, 9'h000});
    @(posedge mclk) src <= 5'h1f;
    step(2);
    #1 chk("pinOut", 16'h0, 16'(pinOut));
    chk("pinOe", 16'h1, 16'(pinOe));
    wr(8'h24, {3'b000, 4'h7, 9'h000});
    step(2);
    #1 chk("pinOe", 16'h0, 16'(pinOe));
    chk("pinWire", 16'h1, 16'(seenLevel));
    @(posedge mclk) extOe <= 1'b1;
    src <= 5'h00;
    for (int s = 0; s < 4; s++) begin
      wr(8'h25, {3'b001, 3'b000, 2'(s), 8'h00});
      rd(8'h25, {3'b001, 3'b000, 2'(s), 8'h00});
      chk("shutdown", 16'(s), 16'(shutdownAction));
      chk("lowPower", 16'h1, 16'(lowPowerSelect));
    end
    wr(8'h24, 16'hffff);
    rd(8'h24, 16'hbfff);
    wr(8'h24, 16'h0124);
    @(posedge mclk) pmbusMode <= 1'b1;
    pmbusPage <= 8'hff;
    rd(8'he8, 16'h0124);
    rd(8'he9, 16'h2300);
    @(posedge mclk) pmbusPage <= 8'h00;
    rd(8'he8, 16'h0000);
    @(posedge mclk) pmbusMode <= 1'b0;
    rd(8'h26, 16'h0000);
    wr(8'h24, 16'h001b);
    pinTo(1'b0, 12'h0, 8'h00);
    pinTo(1'b1, 12'h0, 8'h01);
    chk("allow", 16'h0, 16'(mapWriteAllow));
    wr(8'h25, 16'h0000);
    rd(8'h25, 16'h2300);
    @(posedge mclk) regWrUnlockField <= 1'b1;
    #1 chk("allow", 16'h1, 16'(mapWriteAllow));
    @(posedge mclk) {regWrUnlockField, regWrResetField, regWrViaI2c} <= 3'b011;
    #1 chk("allow", 16'h1, 16'(mapWriteAllow));
    @(posedge mclk) {regWrUnlockField, regWrResetField, regWrViaI2c} <= 3'b010;
    #1 chk("allow", 16'h0, 16'(mapWriteAllow));
    @(posedge mclk) {regWrUnlockField, regWrResetField, regWrViaI2c} <= 3'b001;
    #1 chk("allow", 16'h0, 16'(mapWriteAllow));
    @(posedge mclk) regWrViaI2c <= 1'b0;
    pinTo(1'b0, 12'h0, 8'h00);
    wr(8'h24, 16'h0000);
    pinTo(1'b1, 12'h0, 8'h00);
    // Reset through the pin, driven as a pulse by the far side
    wr(8'h24, 16'h0017);
    pinTo(1'b0, 12'h0, 8'h04);
    pinTo(1'b1, 12'h0, 8'h00);
    rd(8'h24, 16'h0000);
    rd(8'h25, 16'h0000);
    @(posedge mclk) nvmPinCfgSaved <= 1'b1;
    wr(8'h24, 16'h0017);
    pinTo(1'b0, 12'h0, 8'h04);
    pinTo(1'b1, 12'h0, 8'h00);
    rd(8'h24, 16'h0017);
    finish_test;
  end
endmodule
